// ==== ffx_freeze_exit.sv ====
// Freeze entry, pin wake combiner and exit sequencing with register port
// What this block does
// - Exit when all low and high pins meet settings, or any toggle pin changed.
// - Toggle pins latch level before entry; any later difference wakes.
// - Several toggle pins allowed; any one changing is enough (OR).
// - Signature exit only when all selected pins match at once.
// - Wake-high term met on high level, wake-low term on low level.
// - One signature may mix wake-high and wake-low pins.
// - Output-only pins never take part in the exit condition.
// - Non-waking pins float or hold last level while frozen, per pin.
// - Stay-operational option honoured only on processor subsystem pins.
// - Operational pins ignore their frozen-state setting.
// - Freeze-start warning to user logic; done flag to the processor subsystem.
// - Clock conditioner async reset driven by inverted freeze-done flag.
// - Done flag gates fabric async resets and hardened block inputs.
// - Active: 50 MHz base clock from first global, subsystem at 100 MHz.
// - Frozen: subsystem runs from 1 MHz or 50 MHz standby oscillator.
// - Frozen: RAMs held in suspend or sleep retention as configured.
// - Done flag rises before restore and falls after restore completes.
// - Aligned select 1 picks standby clock, 0 picks divided PLL clocks.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
module ffx_freeze_exit
    import ffx_pkg::*;
(
    // Clock and reset
    input  wire logic                CLK,
    input  wire logic                RST_N,
    // Register port
    input  wire logic [3:0]          ADDR,
    input  wire logic [31:0]         WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [31:0]         RDATA,
    // Wake pins, five signals each
    input  wire logic [NUM_PINS-1:0] PIN_IN,
    input  wire logic [NUM_PINS-1:0] PIN_USER_OUT,
    input  wire logic [NUM_PINS-1:0] PIN_USER_OE,
    output logic      [NUM_PINS-1:0] PIN_OUT,
    output logic      [NUM_PINS-1:0] PIN_OE,
    // Clock system status
    input  wire logic                MAIN_PLL_LOCKED,
    // Sequencing outputs
    output logic                     FREEZE_START_WARNING,
    output logic                     FREEZE_DONE_FLAG,
    output logic                     CONDITIONER_ASYNC_RESET_N,
    output logic                     FABRIC_RESET_GATE_N,
    output logic                     FABRIC_GLOBAL_CLOCK_ENABLE,
    output logic                     ALIGNED_CLOCK_SELECT,
    output logic                     STANDBY_FAST_SELECT,
    output logic                     RAM_SLEEP_SELECT,
    output logic                     RAM_RETAIN,
    output logic                     CORE_POWER_OFF
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    ffx_wake_t              wake_mode [NUM_PINS];
    logic [31:0]            wake_lo_reg, wake_hi_reg;
    logic [31:0]            pin_cfg_reg;
    logic [1:0]             misc_cfg_reg;
    logic                   enter_req_reg;
    ffx_state_t             state_reg;
    logic [15:0]            count_reg;
    logic [NUM_PINS-1:0]    snap_reg;
    logic [NUM_PINS-1:0]    last_out_reg;
    logic [NUM_PINS-1:0]    sync1_reg, sync2_reg, sync3_reg, pin_level_reg;
    logic [2:0]             lock_sync_reg;
    logic                   lock_q_reg;
    logic                   wake_seen_reg;

    // Register write side
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wake_lo_reg  <= WAKE_RESET;
            wake_hi_reg  <= WAKE_RESET;
            pin_cfg_reg  <= PIN_RESET;
            misc_cfg_reg <= MISC_RESET;
        end else if (WR && state_reg == ST_ACTIVE) begin
            // Settings are locked outside active mode so a wake term cannot shift
            unique case (ADDR)
                REG_WAKE_LO:  wake_lo_reg  <= WDATA;
                REG_WAKE_HI:  wake_hi_reg  <= WDATA;
                REG_PIN_CFG:  pin_cfg_reg  <= WDATA;
                REG_MISC_CFG: misc_cfg_reg <= WDATA[1:0];
                default: ;
            endcase
        end
    end

    // Entry pulse; refused outside active mode so a late write cannot re-arm a freeze
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            enter_req_reg <= 1'b0;
        end else if (WR && ADDR == REG_CTRL && WDATA[CT_ENTER_POS] && state_reg == ST_ACTIVE) begin
            enter_req_reg <= 1'b1;
        end else begin
            enter_req_reg <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            unique case (ADDR)
                REG_WAKE_LO:   RDATA <= wake_lo_reg;
                REG_WAKE_HI:   RDATA <= wake_hi_reg;
                REG_PIN_CFG:   RDATA <= pin_cfg_reg;
                REG_MISC_CFG:  RDATA <= {30'h0, misc_cfg_reg};
                REG_STATUS:    RDATA <= {24'h0, wake_seen_reg, lock_q_reg,
                                         FREEZE_DONE_FLAG, FREEZE_START_WARNING,
                                         1'b0, state_reg};
                REG_PIN_LEVEL: RDATA <= {24'h0, pin_level_reg};
                default:       RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Wake combiner
    // ------------------------------------------------------------
    // Two bits of mode per pin, low half in one word, high half in the other
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            wake_mode[i] = ffx_wake_t'(i < 4 ? wake_lo_reg[2*i +: 2]
                                              : wake_hi_reg[2*(i-4) +: 2]);
        end
    end

    logic [NUM_PINS-1:0] eligible, sig_member, sig_match, chg_member;
    logic                sig_term, chg_term, wake_now;

    // Combinational on raw pins: the fabric clock is stopped while frozen
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            eligible[i]   = !pin_cfg_reg[PC_OUTO_POS + i];
            sig_member[i] = eligible[i] && (wake_mode[i] == WAKE_LOW ||
                                            wake_mode[i] == WAKE_HIGH);
            sig_match[i]  = !sig_member[i] ||
                            (wake_mode[i] == WAKE_HIGH ? PIN_IN[i] : !PIN_IN[i]);
            chg_member[i] = eligible[i] && wake_mode[i] == WAKE_CHANGE;
        end
        sig_term = (|sig_member) && (&sig_match);
        chg_term = |(chg_member & (PIN_IN ^ snap_reg));
        wake_now = sig_term || chg_term;
    end

    // Pin level synchroniser; only the second and third stages are compared
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1_reg     <= '0;
            sync2_reg     <= '0;
            sync3_reg     <= '0;
            pin_level_reg <= '0;
            lock_sync_reg <= 3'h0;
            lock_q_reg    <= 1'b0;
        end else begin
            sync1_reg     <= PIN_IN;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            pin_level_reg <= (sync2_reg & sync3_reg) | (pin_level_reg & (sync2_reg | sync3_reg));
            lock_sync_reg <= {lock_sync_reg[1:0], MAIN_PLL_LOCKED};
            lock_q_reg    <= &lock_sync_reg[2:1] | (lock_q_reg & |lock_sync_reg[2:1]);
        end
    end

    // Snapshot of toggle pins just before power goes, from synchronised levels
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            snap_reg <= '0;
        end else if (state_reg == ST_WARN && count_reg == 16'(WARN_CYCLES - 1)) begin
            snap_reg <= pin_level_reg;
        end
    end

    // Wake latch; the set term wins over the clear
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wake_seen_reg <= 1'b0;
        end else if (state_reg == ST_FROZEN && wake_now) begin
            wake_seen_reg <= 1'b1;
        end else if (state_reg == ST_ACTIVE) begin
            wake_seen_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Freeze sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= ST_ACTIVE;
            count_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_ACTIVE: begin
                    count_reg <= 16'h0000;
                    if (enter_req_reg) state_reg <= ST_WARN;
                end
                ST_WARN: begin
                    // User housekeeping window before power is removed
                    count_reg <= count_reg + 16'h0001;
                    if (count_reg == 16'(WARN_CYCLES - 1)) begin
                        state_reg <= ST_FROZEN;
                        count_reg <= 16'h0000;
                    end
                end
                ST_FROZEN: begin
                    if (wake_now) state_reg <= ST_EXIT;
                end
                ST_EXIT: begin
                    // Fabric restore while done flag is high
                    count_reg <= count_reg + 16'h0001;
                    if (count_reg == 16'(RESTORE_CYCLES - 1)) begin
                        state_reg <= ST_SYNC;
                        count_reg <= 16'h0000;
                    end
                end
                ST_SYNC: begin
                    // Wait for lock, select move, then settling
                    if (!lock_q_reg || ALIGNED_CLOCK_SELECT) begin
                        count_reg <= 16'h0000;
                    end else if (count_reg == 16'(SETTLE_CYCLES - 1)) begin
                        state_reg <= ST_ACTIVE;
                    end else begin
                        count_reg <= count_reg + 16'h0001;
                    end
                end
                default: state_reg <= ST_ACTIVE;
            endcase
        end
    end

    // Clock and power outputs
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            FREEZE_START_WARNING       <= 1'b0;
            FREEZE_DONE_FLAG           <= 1'b0;
            CONDITIONER_ASYNC_RESET_N  <= 1'b1;
            FABRIC_RESET_GATE_N        <= 1'b1;
            FABRIC_GLOBAL_CLOCK_ENABLE <= 1'b1;
            ALIGNED_CLOCK_SELECT       <= 1'b0;
            STANDBY_FAST_SELECT        <= 1'b0;
            RAM_SLEEP_SELECT           <= 1'b0;
            RAM_RETAIN                 <= 1'b0;
            CORE_POWER_OFF             <= 1'b0;
        end else begin
            FREEZE_START_WARNING      <= (state_reg == ST_WARN);
            FREEZE_DONE_FLAG          <= (state_reg == ST_EXIT);
            CONDITIONER_ASYNC_RESET_N <= !(state_reg == ST_EXIT);
            FABRIC_RESET_GATE_N       <= !(state_reg == ST_EXIT ||
                                           state_reg == ST_FROZEN);
            FABRIC_GLOBAL_CLOCK_ENABLE <= (state_reg == ST_ACTIVE);
            // Standby clock while frozen, back to PLL once lock is seen
            ALIGNED_CLOCK_SELECT <= (state_reg == ST_FROZEN) ||
                                    (state_reg == ST_EXIT) ||
                                    (state_reg == ST_SYNC && !lock_q_reg);
            STANDBY_FAST_SELECT <= misc_cfg_reg[MC_STBY_POS];
            RAM_SLEEP_SELECT    <= misc_cfg_reg[MC_RAM_POS];
            RAM_RETAIN          <= (state_reg == ST_FROZEN);
            CORE_POWER_OFF      <= (state_reg == ST_FROZEN);
        end
    end

    // ------------------------------------------------------------
    // Frozen pin behaviour
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] oper, frozen_now;

    // Operational only for processor subsystem pins
    assign oper       = pin_cfg_reg[PC_OPER_POS +: NUM_PINS] & pin_cfg_reg[PC_PROC_POS +: NUM_PINS];
    assign frozen_now = {NUM_PINS{state_reg == ST_FROZEN}} & ~oper;

    // Remember the driven level so hold mode can replay it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            last_out_reg <= '0;
        end else if (state_reg == ST_ACTIVE || state_reg == ST_WARN) begin
            last_out_reg <= PIN_USER_OUT;
        end
    end

    // Wake pins are inputs while frozen; others float or hold
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PIN_OUT <= '0;
            PIN_OE  <= '0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (frozen_now[i]) begin
                    PIN_OUT[i] <= last_out_reg[i];
                    PIN_OE[i]  <= pin_cfg_reg[PC_HOLD_POS + i] &&
                                  !(sig_member[i] || chg_member[i]);
                end else begin
                    PIN_OUT[i] <= PIN_USER_OUT[i];
                    PIN_OE[i]  <= PIN_USER_OE[i];
                end
            end
        end
    end

    // Active-mode clocks (50 MHz base, 100 MHz subsystem) live outside this block

endmodule : ffx_freeze_exit

// ==== ffx_pkg.sv ====
// Package of constants and types for the freeze wake and exit controller
package ffx_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PINS = 8;

    // ------------------------------------------------------------
    // Per-pin wake settings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WAKE_OFF    = 2'h0,
        WAKE_LOW    = 2'h1,
        WAKE_HIGH   = 2'h2,
        WAKE_CHANGE = 2'h3
    } ffx_wake_t;

    // Sequencer states, Gray along the freeze path
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h0,
        ST_WARN   = 3'h1,
        ST_FROZEN = 3'h3,
        ST_EXIT   = 3'h2,
        ST_SYNC   = 3'h6
    } ffx_state_t;

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [3:0] REG_WAKE_LO   = 4'h0;
    localparam logic [3:0] REG_WAKE_HI   = 4'h1;
    localparam logic [3:0] REG_PIN_CFG   = 4'h2;
    localparam logic [3:0] REG_MISC_CFG  = 4'h3;
    localparam logic [3:0] REG_CTRL      = 4'h4;
    localparam logic [3:0] REG_STATUS    = 4'h5;
    localparam logic [3:0] REG_PIN_LEVEL = 4'h6;

    // Pin config: [7:0] hold-last-value, [15:8] operational, [23:16] processor pin,
    // [31:24] output-only
    localparam int PC_HOLD_POS = 0;
    localparam int PC_OPER_POS = 8;
    localparam int PC_PROC_POS = 16;
    localparam int PC_OUTO_POS = 24;
    localparam int MC_STBY_POS = 0;     // 1 selects fast standby oscillator
    localparam int MC_RAM_POS  = 1;     // 1 selects sleep retention
    localparam int CT_ENTER_POS = 0;    // Write 1 requests freeze entry

    localparam logic [31:0] WAKE_RESET = 32'h0000_0000;
    localparam logic [31:0] PIN_RESET  = 32'h0000_0000;
    localparam logic [1:0]  MISC_RESET = 2'h0;

    // ------------------------------------------------------------
    // Timing at 250 MHz
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 250;
    localparam int WARN_TIME_US   = 10;
    localparam int WARN_CYCLES    = WARN_TIME_US * CLK_MHZ;   // Longest time, exact
    localparam int SETTLE_TIME_NS = 100;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int RESTORE_CYCLES = 4;

endpackage : ffx_pkg

// ==== ffx_pin_model.sv ====
// Wake switches and main PLL lock as seen from outside the freeze controller
module ffx_pin_model #(
    parameter logic [7:0] PULL     = 8'h0f,
    parameter int         LOCK_DLY = 12
) (
    // Clock and core power state
    input  wire logic       clk,
    input  wire logic       power_off,
    // Switch positions
    input  wire logic [7:0] sw_level,
    input  wire logic [7:0] sw_closed,
    // Levels handed to the block
    output logic      [7:0] pin_lvl,
    output logic            pll_lock
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt_reg = LOCK_DLY;

    // An open switch leaves the pin at its pull level, never the last value
    assign pin_lvl  = (sw_level & sw_closed) | (PULL & ~sw_closed);
    assign pll_lock = (cnt_reg >= LOCK_DLY);

    // Lock is lost with core power and comes back only after a delay
    always_ff @(posedge clk) begin
        if (power_off) begin
            cnt_reg <= 0;
        end else if (cnt_reg < LOCK_DLY) begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule : ffx_pin_model

// ==== ffx_freeze_exit_monitor.sv ====
// Concurrent checks on the ports of the freeze wake and exit controller
module ffx_freeze_exit_monitor
    import ffx_pkg::*;
(
    // Clock, reset and read port
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // Clock system and sequencing
    input wire logic        MAIN_PLL_LOCKED,
    input wire logic        FREEZE_START_WARNING,
    input wire logic        FREEZE_DONE_FLAG,
    input wire logic        CONDITIONER_ASYNC_RESET_N,
    input wire logic        FABRIC_RESET_GATE_N,
    input wire logic        FABRIC_GLOBAL_CLOCK_ENABLE,
    input wire logic        ALIGNED_CLOCK_SELECT,
    input wire logic        RAM_RETAIN,
    input wire logic        CORE_POWER_OFF
);
    logic        warn_q_reg;
    logic [15:0] warn_cnt_reg;

    // Length of the latest warning run, kept after it ends
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            warn_q_reg   <= 1'b0;
            warn_cnt_reg <= 16'h0;
        end else begin
            warn_q_reg <= FREEZE_START_WARNING;
            if (FREEZE_START_WARNING) begin
                warn_cnt_reg <= warn_q_reg ? warn_cnt_reg + 16'h1 : 16'h1;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // --------------------------------------------------------------
    // Exit steps
    // --------------------------------------------------------------
    sequence restore_s;
        FREEZE_DONE_FLAG [*4] ##1 !FREEZE_DONE_FLAG;
    endsequence
    sequence restore_start_s;
        ##[0:2] FREEZE_DONE_FLAG;
    endsequence

    warn_window_a : assert property ($rose(CORE_POWER_OFF) |->
        warn_cnt_reg == 16'(WARN_CYCLES))
        else $error("warning window length wrong");
    warn_first_a : assert property (FREEZE_START_WARNING |->
        !CORE_POWER_OFF && !FREEZE_DONE_FLAG) else $error("warning overlaps freeze");
    restore_len_a : assert property ($rose(FREEZE_DONE_FLAG) |-> restore_s)
        else $error("done flag length wrong");
    exit_done_a : assert property ($fell(CORE_POWER_OFF) |-> restore_start_s)
        else $error("no done flag on exit");
    cond_reset_a : assert property (FREEZE_DONE_FLAG && $past(FREEZE_DONE_FLAG) |->
        !CONDITIONER_ASYNC_RESET_N) else $error("conditioner not held in reset");
    gate_frozen_a : assert property (FREEZE_DONE_FLAG || CORE_POWER_OFF |->
        !FABRIC_RESET_GATE_N && !FABRIC_GLOBAL_CLOCK_ENABLE) else $error("fabric not gated");
    retain_sel_a : assert property (CORE_POWER_OFF |->
        RAM_RETAIN && ALIGNED_CLOCK_SELECT) else $error("frozen retention or select wrong");
    clk_enable_a : assert property ($rose(FABRIC_GLOBAL_CLOCK_ENABLE) |->
        MAIN_PLL_LOCKED && $past(ALIGNED_CLOCK_SELECT, 20) == 1'b0)
        else $error("clock enabled before lock and settle");
    rd_idle_a : assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside read slot");
endmodule : ffx_freeze_exit_monitor

bind ffx_freeze_exit ffx_freeze_exit_monitor ffx_freeze_exit_monitor_i (
    .CLK, .RST_N, .RD, .RDATA, .MAIN_PLL_LOCKED, .FREEZE_START_WARNING, .FREEZE_DONE_FLAG,
    .CONDITIONER_ASYNC_RESET_N, .FABRIC_RESET_GATE_N, .FABRIC_GLOBAL_CLOCK_ENABLE,
    .ALIGNED_CLOCK_SELECT, .RAM_RETAIN, .CORE_POWER_OFF
);

// ==== ffx_freeze_exit_tb_top.sv ====
// Self-checking bench for the freeze wake and exit controller
module ffx_freeze_exit_tb_top
    import ffx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic CLK, RST_N, WR, RD, MAIN_PLL_LOCKED, FREEZE_START_WARNING, FREEZE_DONE_FLAG;
    logic CONDITIONER_ASYNC_RESET_N, FABRIC_RESET_GATE_N, FABRIC_GLOBAL_CLOCK_ENABLE;
    logic ALIGNED_CLOCK_SELECT, STANDBY_FAST_SELECT, RAM_SLEEP_SELECT, RAM_RETAIN, CORE_POWER_OFF;
    logic [3:0]  ADDR;
    logic [31:0] WDATA, RDATA;
    logic [7:0]  PIN_IN, PIN_USER_OUT, PIN_USER_OE, PIN_OUT, PIN_OE, sw_level, sw_closed;
    int          err_total, cmp_count;
    integer      seed = 32'hf4a3;

    ffx_freeze_exit ffx_freeze_exit_i (.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .PIN_IN,
        .PIN_USER_OUT, .PIN_USER_OE, .PIN_OUT, .PIN_OE, .MAIN_PLL_LOCKED, .FREEZE_START_WARNING,
        .FREEZE_DONE_FLAG, .CONDITIONER_ASYNC_RESET_N, .FABRIC_RESET_GATE_N,
        .FABRIC_GLOBAL_CLOCK_ENABLE, .ALIGNED_CLOCK_SELECT, .STANDBY_FAST_SELECT,
        .RAM_SLEEP_SELECT, .RAM_RETAIN, .CORE_POWER_OFF);
    ffx_pin_model ffx_pin_model_i (.clk(CLK), .power_off(CORE_POWER_OFF), .sw_level,
        .sw_closed, .pin_lvl(PIN_IN), .pll_lock(MAIN_PLL_LOCKED));

    // Free-running 250 MHz clock
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // --------------------------------------------------------------
    // Checking and bus tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge CLK);
        {ADDR, RD} <= {a, 1'b1};
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        d = RDATA;
    endtask : rd

    // Bounded wait on power-off (w 0) or clock enable (w 1)
    task automatic wait_on(input int w, input logic v, input int lim);
        int n = 0;
        while (((w == 0) ? CORE_POWER_OFF : FABRIC_GLOBAL_CLOCK_ENABLE) !== v) begin
            @(negedge CLK);
            n++;
            if (n > lim) begin
                err_total++;
                $display("BAD wait %0d expected %h seen timeout", w, v);
                final_report();
            end
        end
    endtask : wait_on

    task automatic do_reset;
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (20) @(posedge CLK);
        @(negedge CLK);
        chk("reset_out", 32'h0e0, 32'({FREEZE_START_WARNING, FREEZE_DONE_FLAG,
            CONDITIONER_ASYNC_RESET_N, FABRIC_RESET_GATE_N, FABRIC_GLOBAL_CLOCK_ENABLE,
            ALIGNED_CLOCK_SELECT, STANDBY_FAST_SELECT, RAM_SLEEP_SELECT, RAM_RETAIN,
            CORE_POWER_OFF}));
        chk("reset_pins", 32'h0, 32'(RDATA[15:0] | {PIN_OE, PIN_OUT}));
        @(posedge CLK);
        RST_N <= 1'b1;
    endtask : do_reset

    // --------------------------------------------------------------
    // Expectation functions
    // --------------------------------------------------------------
    function automatic ffx_wake_t mode_of(input logic [31:0] lo, hi, input int i);
        return ffx_wake_t'((i < 4) ? lo[2*i +: 2] : hi[2*(i-4) +: 2]);
    endfunction : mode_of

    function automatic logic wake_exp(input logic [31:0] lo, hi, pc, input logic [7:0] sn, nw);
        logic any, ok, chg;
        {any, ok, chg} = 3'b010;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!pc[PC_OUTO_POS+i]) begin
                case (mode_of(lo, hi, i))
                    WAKE_LOW:    {any, ok} = {1'b1, ok & !nw[i]};
                    WAKE_HIGH:   {any, ok} = {1'b1, ok & nw[i]};
                    WAKE_CHANGE: chg = chg | (nw[i] != sn[i]);
                    default:     ;
                endcase
            end
        end
        return chg || (any && ok);
    endfunction : wake_exp

    function automatic logic [7:0] sig_fit(input logic [31:0] lo, hi, input logic [7:0] b);
        for (int i = 0; i < NUM_PINS; i++) begin
            if (mode_of(lo, hi, i) == WAKE_LOW) b[i] = 1'b0;
            if (mode_of(lo, hi, i) == WAKE_HIGH) b[i] = 1'b1;
        end
        return b;
    endfunction : sig_fit

    // One freeze: set up, enter, probe frozen pins, then a mid and a matching pin step
    task automatic ffz(input logic [31:0] lo, hi, pc, input logic [1:0] misc,
                       input logic [7:0] bef, mid, cl);
        logic [7:0]  part, e_oe, e_out, u_oe, u_out, snap;
        logic [31:0] d;
        logic        woke;
        wr(REG_WAKE_LO, lo);
        wr(REG_WAKE_HI, hi);
        wr(REG_PIN_CFG, pc);
        wr(REG_MISC_CFG, {30'h0, misc});
        {sw_level, sw_closed} <= {bef, 8'hff};
        {PIN_USER_OUT, PIN_USER_OE} <= 16'($random(seed));
        repeat (8) @(posedge CLK);
        {snap, u_oe, u_out} = {PIN_IN, PIN_USER_OE, PIN_USER_OUT};
        woke = wake_exp(lo, hi, pc, snap, snap);
        rd(REG_PIN_LEVEL, d);
        chk("pin_level", 32'(snap), d);
        wr(REG_CTRL, 32'h1);
        wait_on(0, 1'b1, 2600);
        if (!woke) begin
            @(posedge CLK);
            {PIN_USER_OUT, PIN_USER_OE} <= ~{u_out, u_oe};
            wr(REG_MISC_CFG, {30'h0, ~misc});
            repeat (4) @(negedge CLK);
            for (int i = 0; i < NUM_PINS; i++) begin
                part[i] = mode_of(lo, hi, i) != WAKE_OFF && !pc[PC_OUTO_POS+i];
                if (pc[PC_OPER_POS+i] && pc[PC_PROC_POS+i]) {e_oe[i], e_out[i]} = ~{u_oe[i], u_out[i]};
                else if (pc[PC_HOLD_POS+i]) {e_oe[i], e_out[i]} = {1'b1, u_out[i]};
                else {e_oe[i], e_out[i]} = 2'b00;
            end
            chk("pin_oe", 32'(e_oe & ~part), 32'(PIN_OE & ~part));
            chk("pin_out", 32'(e_out & e_oe & ~part), 32'(PIN_OUT & e_oe & ~part));
            chk("standby_sel", 32'(misc), 32'({RAM_SLEEP_SELECT, STANDBY_FAST_SELECT}));
        end
        for (int s = 0; s < 2 && !woke; s++) begin
            @(posedge CLK);
            sw_level <= s ? sig_fit(lo, hi, PIN_IN) : mid;
            sw_closed <= s ? 8'hff : cl;
            repeat (20) @(negedge CLK);
            woke = wake_exp(lo, hi, pc, snap, PIN_IN);
            chk("power_off", 32'(!woke), 32'(CORE_POWER_OFF));
        end
        if (woke) begin
            wait_on(1, 1'b1, 300);
            rd(REG_MISC_CFG, d);
            chk("misc_kept", 32'(misc), d & 32'h3);
        end else begin
            do_reset();
        end
    endtask : ffz

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [31:0] d, r;
        {RST_N, WR, RD, ADDR, WDATA, PIN_USER_OUT, PIN_USER_OE} = '0;
        {sw_level, sw_closed, err_total, cmp_count} = {16'h00ff, 64'h0};
        do_reset();
        rd(4'hf, d);
        chk("unmapped", 32'h0, d);
        // Reset values, then random write and read back, back to back
        for (int a = 0; a < 4; a++) begin
            rd(4'(a), d);
            chk("reg_reset", 32'h0, d);
            r = $random(seed);
            wr(4'(a), r);
            rd(4'(a), d);
            chk("reg_back", (a == 3) ? r & 32'h3 : r, d);
        end
        chk("sel_copy", r & 32'h3, 32'({RAM_SLEEP_SELECT, STANDBY_FAST_SELECT}));
        ffz(32'h30, 32'h0, 32'h0010_3003, 2'h1, 8'h00, 8'h04, 8'hff);
        ffz(32'h0, 32'h3c, 32'h00f0_f00f, 2'h2, 8'h20, 8'h20, 8'hff);
        ffz(32'h6, 32'h0, 32'h0000_00f0, 2'h3, 8'h02, 8'h03, 8'hff);
        ffz(32'hc0, 32'h0, 32'h0800_0000, 2'h0, 8'h00, 8'h08, 8'hff);
        for (int k = 0; k < 3; k++) begin
            ffz($random(seed), $random(seed), $random(seed), 2'($random(seed)),
                8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
        end
        final_report();
    end
endmodule : ffx_freeze_exit_tb_top
